// ### mbr_pkg.sv
// Constants, states and carriers for the multi-bank bring-up controller.
// Assumes a single 100 MHz core clock; slower rates come from enables.
`default_nettype none

package mbr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_BANKS   = 2;
    localparam int TBYTE_W     = 4;
    localparam int CNT_W       = 16;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PLL_RST_MIN_NS  = 1000;
    localparam int PLL_RST_CYCLES  =
        (PLL_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLICE_WAIT_APP  = 64;
    localparam int APP_DIV         = 2;
    localparam int SYNC_STAGES     = 2;

    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [9:0] {
        ST_IDLE      = 10'h001,
        ST_PLL_RST   = 10'h002,
        ST_SLICE_RST = 10'h004,
        ST_STROBE    = 10'h008,
        ST_HOLD      = 10'h010,
        ST_LOCK      = 10'h020,
        ST_RELEASE   = 10'h040,
        ST_WAIT64    = 10'h080,
        ST_PHY_EN    = 10'h100,
        ST_DONE_WAIT = 10'h200
    } mbr_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Reset and clock-gate drive toward the banks
    typedef struct packed {
        logic [NUM_BANKS-1:0] pll_reset;
        logic                 slice_delay_reset;
        logic                 slice_data_reset;
        logic                 group_ctrl_reset;
        logic                 strobe_clock_run;
        logic                 phy_clock_gate;
        logic                 bank_sm_reset;
    } mbr_drive_t;

    localparam mbr_drive_t DRIVE_RESET = '{
        pll_reset:         {NUM_BANKS{1'b1}},
        slice_delay_reset: 1'b1,
        slice_data_reset:  1'b1,
        group_ctrl_reset:  1'b1,
        strobe_clock_run:  1'b0,
        phy_clock_gate:    1'b0,
        bank_sm_reset:     1'b1
    };

endpackage : mbr_pkg

`default_nettype wire

// ### mbr_sync.sv
// Two flip-flop synchronizer for a bus of independent level signals.
// Assumes each bit is a slow level; words are not kept coherent.
`default_nettype none

module mbr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    ////////////////////////////////////////////////////////////////////////
    // First stage is read only by the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (!rst_b)
                begin
                    meta[g]     <= 1'b0;
                    sync_out[g] <= 1'b0;
                end
                else
                begin
                    meta[g]     <= async_in[g];
                    sync_out[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule : mbr_sync

`default_nettype wire

// ### mbr_delay_count.sv
// Down-counter that reports once a loaded count of enabled ticks has run.
// Assumes load and tick come from logic on core_clk.
`default_nettype none

module mbr_delay_count (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    // Control
    input  wire logic                     load,
    input  wire logic [mbr_pkg::CNT_W-1:0] load_value,
    input  wire logic                     tick,
    // Status
    output logic                          expired
);

    logic [mbr_pkg::CNT_W-1:0] remain;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            remain <= mbr_pkg::CNT_ZERO;
        else if (load)
            remain <= load_value;
        else if (tick && remain != mbr_pkg::CNT_ZERO)
            remain <= remain - mbr_pkg::CNT_ONE;
    end

    // Expiry is held low on the load cycle so a stale zero never leaks
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            expired <= 1'b0;
        else if (load)
            expired <= 1'b0;
        else
            expired <= (remain == mbr_pkg::CNT_ZERO);
    end

endmodule : mbr_delay_count

`default_nettype wire

// ### mbr_bringup.sv
// Host-side reset and bring-up controller for a multi-bank native I/O
// interface. Assumes all bank status pins are asynchronous to core_clk
// and that core_clk serves as register-interface and application clock.
//
// Behaviour
// RL1: Apply reset: PLL reset first, then slice resets, then stop strobes.
// RL2: Hold PLL reset the minimum time, then run the release sequence.
// RL3: Transmit slices clock from the PLL; application clock loads data.
// RL4: Application clock is the receive queue read clock.
// RL5: One common application clock for all banks; aux PLL outputs unused.
// RL6: Reset state machine inputs must be in the register-interface domain.
// RL7: All banks, PLLs and state machines reset simultaneously.
// RL8: Lock flags synchronized, then ANDed, before feeding state machines.
// RL9: Per-bank sequence-done flags ANDed into one interface-ready signal.
// RL10: Interface-ready, synchronized, drives all four tristate byte bits; the code drives them only when tx_design is set.
// RL11: Receive queue reads stay off until interface-ready goes high.
// RL12: Read enable is a flop of the far-end slice's inverted empty flag.
// RL13: Shared-bank interfaces start together, may finish separately.
// RL14: Shared-bank register clocks differ by no more than a factor four.
// RL15: Shared-bank lock flags ANDed, resynchronized into each domain.
// RL16: Wait 64 application cycles after slice release before PHY clock.
// RL17: Ready toward tristate control passes a two-register synchronizer.
// RL18: Two-flop synchronizers on crossings; combined signals registered.
`default_nettype none

module mbr_bringup (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst_b,
    // User orders
    input  wire logic                           start_reset,
    input  wire logic                           rx_design,
    input  wire logic                           tx_design,
    output logic                                sequence_busy,
    output logic                                whole_interface_ok,
    // Bank status pins
    input  wire logic [mbr_pkg::NUM_BANKS-1:0]  pll_lock_flag,
    input  wire logic [mbr_pkg::NUM_BANKS-1:0]  bank_sequence_complete,
    input  wire logic                           far_slice_queue_empty,
    // Bank drive
    output mbr_pkg::mbr_drive_t                 bank_drive,
    output logic [mbr_pkg::TBYTE_W-1:0]         tristate_byte_ctrl,
    output logic                                queue_read_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    mbr_pkg::mbr_state_t             state;
    mbr_pkg::mbr_state_t             next_state;
    logic [mbr_pkg::NUM_BANKS-1:0]   lock_sync;
    logic [mbr_pkg::NUM_BANKS-1:0]   done_sync;
    logic                            empty_sync;
    logic                            all_pll_lock_flag;
    logic                            all_done;
    logic                            app_tick;
    logic [$clog2(mbr_pkg::APP_DIV)-1:0] app_div;
    logic                            timer_load;
    logic [mbr_pkg::CNT_W-1:0]       timer_value;
    logic                            timer_tick;
    logic                            timer_expired;
    logic                            timer_armed;
    logic                            ready_stage;
    logic                            ready_app;
    logic                            start_seen;

    ////////////////////////////////////////////////////////////////////////
    // Reduce a flag bus only when every bank reports
    function automatic logic all_set(
        input logic [mbr_pkg::NUM_BANKS-1:0] flags
    );
        all_set = &flags;
    endfunction : all_set

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the register-interface domain
    mbr_sync #(
        .WIDTH    (mbr_pkg::NUM_BANKS)
    ) u_lock_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (pll_lock_flag),
        .sync_out (lock_sync)              // RL8 RL18
    );

    mbr_sync #(
        .WIDTH    (mbr_pkg::NUM_BANKS)
    ) u_done_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (bank_sequence_complete),
        .sync_out (done_sync)              // RL18
    );

    mbr_sync #(
        .WIDTH    (1)
    ) u_empty_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (far_slice_queue_empty),
        .sync_out (empty_sync)
    );

    // Registered so the sequencer never sees a glitch
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            all_pll_lock_flag <= 1'b0;
        else
            all_pll_lock_flag <= all_set(lock_sync);  // RL6 RL8 RL14 RL15 RL18
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            all_done <= 1'b0;
        else
            all_done <= all_set(done_sync);    // RL9 RL18
    end

    ////////////////////////////////////////////////////////////////////////
    // Application-rate enable
    // Application clock is an enable, so the wait counts its ticks
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            app_div  <= '0;
            app_tick <= 1'b0;
        end
        else
        begin
            app_tick <= (app_div == '0);
            if (app_div == $bits(app_div)'(mbr_pkg::APP_DIV - 1))
                app_div <= '0;
            else
                app_div <= app_div + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared wait timer
    mbr_delay_count u_timer (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .load       (timer_load),
        .load_value (timer_value),
        .tick       (timer_tick),
        .expired    (timer_expired)
    );

    always_comb
    begin
        timer_load  = 1'b0;
        timer_value = mbr_pkg::CNT_ZERO;
        timer_tick  = 1'b1;
        if (state == mbr_pkg::ST_STROBE)
        begin
            timer_load  = 1'b1;
            timer_value = mbr_pkg::CNT_W'(mbr_pkg::PLL_RST_CYCLES);  // RL2
        end
        else if (state == mbr_pkg::ST_RELEASE)
        begin
            timer_load  = 1'b1;
            timer_value = mbr_pkg::CNT_W'(mbr_pkg::SLICE_WAIT_APP); // RL16
        end
        if (state == mbr_pkg::ST_WAIT64)
            timer_tick = app_tick;
    end

    // Expiry lags the load by a cycle, so arm a cycle later
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            timer_armed <= 1'b0;
        else
            timer_armed <= timer_load ? 1'b0 : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start request capture
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            start_seen <= 1'b0;
        else if (state == mbr_pkg::ST_PLL_RST)
            start_seen <= 1'b0;
        else if (start_reset)
            start_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // Power-up counts as an applied reset: bring-up runs unprompted
    always_comb
    begin
        next_state = state;
        case (state)
            mbr_pkg::ST_IDLE:
                if (start_seen)
                    next_state = mbr_pkg::ST_PLL_RST;
            mbr_pkg::ST_PLL_RST:
                next_state = mbr_pkg::ST_SLICE_RST;            // RL1
            mbr_pkg::ST_SLICE_RST:
                next_state = mbr_pkg::ST_STROBE;               // RL1
            mbr_pkg::ST_STROBE:
                next_state = mbr_pkg::ST_HOLD;
            mbr_pkg::ST_HOLD:
                if (timer_armed && timer_expired)
                    next_state = mbr_pkg::ST_LOCK;             // RL2
            mbr_pkg::ST_LOCK:
                if (all_pll_lock_flag)
                    next_state = mbr_pkg::ST_RELEASE;
            mbr_pkg::ST_RELEASE:
                next_state = mbr_pkg::ST_WAIT64;
            mbr_pkg::ST_WAIT64:
                if (timer_armed && timer_expired)
                    next_state = mbr_pkg::ST_PHY_EN;           // RL16
            mbr_pkg::ST_PHY_EN:
                next_state = mbr_pkg::ST_DONE_WAIT;
            mbr_pkg::ST_DONE_WAIT:
                if (start_seen)
                    next_state = mbr_pkg::ST_PLL_RST;
            default:
                next_state = mbr_pkg::ST_PLL_RST;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            state <= mbr_pkg::ST_PLL_RST;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive toward the banks
    // One shared vector per reset; per-bank skew would misalign banks
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            bank_drive <= mbr_pkg::DRIVE_RESET;
        else
        begin
            case (next_state)
                mbr_pkg::ST_PLL_RST:
                begin
                    bank_drive.pll_reset     <= {mbr_pkg::NUM_BANKS{1'b1}};
                    bank_drive.bank_sm_reset <= 1'b1;          // RL7 RL13
                    bank_drive.phy_clock_gate <= 1'b0;
                end
                mbr_pkg::ST_SLICE_RST:
                begin
                    bank_drive.slice_delay_reset <= 1'b1;      // RL1
                    bank_drive.slice_data_reset  <= 1'b1;
                    bank_drive.group_ctrl_reset  <= 1'b1;
                end
                mbr_pkg::ST_STROBE:
                    bank_drive.strobe_clock_run <= 1'b0;       // RL1
                mbr_pkg::ST_LOCK:
                begin
                    bank_drive.pll_reset     <= '0;            // RL2 RL7
                    bank_drive.bank_sm_reset <= 1'b0;          // RL7 RL13
                end
                mbr_pkg::ST_RELEASE:
                begin
                    bank_drive.slice_delay_reset <= 1'b0;
                    bank_drive.slice_data_reset  <= 1'b0;
                    bank_drive.group_ctrl_reset  <= 1'b0;
                end
                mbr_pkg::ST_PHY_EN:
                    bank_drive.phy_clock_gate <= 1'b1;         // RL16
                mbr_pkg::ST_DONE_WAIT:
                    if (all_done)
                        bank_drive.strobe_clock_run <= 1'b1;
                default:
                    bank_drive <= bank_drive;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interface ready and its application-side use
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            whole_interface_ok <= 1'b0;
        else
            whole_interface_ok <= (state == mbr_pkg::ST_DONE_WAIT)
                                  && all_done && !start_seen;  // RL9
    end

    // Two registers toward the application domain
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ready_stage <= 1'b0;
            ready_app   <= 1'b0;
        end
        else
        begin
            ready_stage <= whole_interface_ok;                 // RL17
            ready_app   <= ready_stage;
        end
    end

    // Transmit-only use of the tristate control; idle low elsewhere
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            tristate_byte_ctrl <= '0;
        else
            tristate_byte_ctrl <=
                {mbr_pkg::TBYTE_W{ready_app && tx_design}};   // RL3 RL10
    end

    // Reads only once the whole interface is up
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            queue_read_enable <= 1'b0;
        else
            queue_read_enable <= ready_app && rx_design
                                 && !empty_sync;   // RL4 RL5 RL11 RL12
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            sequence_busy <= 1'b1;
        else
            sequence_busy <= (next_state != mbr_pkg::ST_DONE_WAIT)
                             || !all_done;
    end

endmodule : mbr_bringup

`default_nettype wire

// ### mbr_checker.sv
// Port assertions for the multi-bank bring-up controller.
// Assumes it is bound to mbr_bringup; single clock, sync reset.
`default_nettype none

module mbr_checker (
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          rst_b,
    // Orders and status
    input wire logic                          tx_design,
    input wire logic                          whole_interface_ok,
    input wire logic [mbr_pkg::NUM_BANKS-1:0] pll_lock_flag,
    input wire logic [mbr_pkg::NUM_BANKS-1:0] bank_sequence_complete,
    input wire logic                          far_slice_queue_empty,
    // Drive
    input wire mbr_pkg::mbr_drive_t           bank_drive,
    input wire logic [mbr_pkg::TBYTE_W-1:0]   tristate_byte_ctrl,
    input wire logic                          queue_read_enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Cycles with PLL reset held, and with slices free
    logic [15:0] hold_cnt;
    logic [15:0] free_cnt;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !bank_drive.pll_reset[0])
            hold_cnt <= 16'h0000;
        else if (hold_cnt != 16'hffff)
            hold_cnt <= hold_cnt + 16'h0001;
        if (!rst_b || bank_drive.slice_data_reset)
            free_cnt <= 16'h0000;
        else if (free_cnt != 16'hffff)
            free_cnt <= free_cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    a_slice_after_pll: assert property (
        $rose(bank_drive.pll_reset[0]) |-> !bank_drive.slice_data_reset
        ##1 (bank_drive.slice_data_reset && bank_drive.slice_delay_reset))
        else $error("slice reset late");
    a_strobe_stop_last: assert property (
        $rose(bank_drive.slice_data_reset) |->
        bank_drive.strobe_clock_run ##1 !bank_drive.strobe_clock_run)
        else $error("strobe stop late");
    a_pll_hold_min: assert property (
        $fell(bank_drive.pll_reset[0]) |->
        hold_cnt >= mbr_pkg::PLL_RST_CYCLES)
        else $error("pll reset too short");
    a_pll_bits_same: assert property (
        bank_drive.pll_reset == 2'b00 || bank_drive.pll_reset == 2'b11)
        else $error("bank pll resets differ");
    a_lock_before_go: assert property (
        $fell(bank_drive.slice_data_reset) |->
        $past(pll_lock_flag, 4) == 2'b11)
        else $error("slices freed before lock");
    a_slices_follow: assert property (
        $fell(bank_drive.slice_data_reset) |->
        bank_drive.pll_reset == 2'b00 && !bank_drive.phy_clock_gate)
        else $error("slices freed before pll");
    a_phy_wait_64: assert property (
        $rose(bank_drive.phy_clock_gate) |->
        free_cnt >= 2 * mbr_pkg::SLICE_WAIT_APP - 1)
        else $error("phy clock too soon");
    a_ok_after_done: assert property (
        $rose(whole_interface_ok) |->
        $past(bank_sequence_complete, 2) == 2'b11)
        else $error("ready before all banks done");
    a_tbyte_all_bits: assert property (
        tristate_byte_ctrl != 4'h0 |->
        tristate_byte_ctrl == 4'hf && $past(whole_interface_ok, 3))
        else $error("tristate not synced ready");
    a_tbyte_rises: assert property (
        $rose(whole_interface_ok) && tx_design |->
        ##[2:4] tristate_byte_ctrl == 4'hf)
        else $error("tristate missed ready");
    a_read_gated: assert property (
        queue_read_enable |-> $past(whole_interface_ok, 3)
        && !$past(far_slice_queue_empty, 3))
        else $error("read while not ready or empty");

    c_ok_up: cover property ($rose(whole_interface_ok));
    c_phy_on: cover property ($rose(bank_drive.phy_clock_gate));
    c_reading: cover property ($rose(queue_read_enable));

endmodule : mbr_checker

`default_nettype wire

// ### mbr_bank_model.sv
// Behavioural model of the banks: PLL lock and sequence-done per bank.
// Assumes the controller's drive struct; slow stretches all delays.
`default_nettype none

module mbr_bank_model (
    // Clock
    input wire logic                           core_clk,
    // Bench control
    input wire logic                           slow,
    input wire logic                           no_data,
    // Controller drive
    input wire mbr_pkg::mbr_drive_t            bank_drive,
    // Bank status
    output logic [mbr_pkg::NUM_BANKS-1:0]      pll_lock_flag,
    output logic [mbr_pkg::NUM_BANKS-1:0]      bank_sequence_complete,
    output logic                               far_slice_queue_empty
);
    logic [7:0] lk_cnt [mbr_pkg::NUM_BANKS];
    logic [7:0] dn_cnt [mbr_pkg::NUM_BANKS];

    always_ff @(posedge core_clk)
    begin
        for (int b = 0; b < mbr_pkg::NUM_BANKS; b++)
        begin
            if (bank_drive.pll_reset[b])
                lk_cnt[b] <= 8'h00;
            else if (lk_cnt[b] != 8'hff)
                lk_cnt[b] <= lk_cnt[b] + 8'h01;
            // Calibration needs the phy clock; reset wipes it
            if (bank_drive.bank_sm_reset || !bank_drive.phy_clock_gate)
                dn_cnt[b] <= 8'h00;
            else if (dn_cnt[b] != 8'hff)
                dn_cnt[b] <= dn_cnt[b] + 8'h01;
        end
    end

    always_comb
    begin
        for (int b = 0; b < mbr_pkg::NUM_BANKS; b++)
        begin
            pll_lock_flag[b] = lk_cnt[b] >= (slow ? 8'h28 : 8'h05);
            // Banks finish at different times when prompt
            bank_sequence_complete[b] = dn_cnt[b] >=
                (slow ? 8'h3c : 8'h03 + 8'(b * 4));
        end
    end

    // Queue stays empty without strobes or data
    assign far_slice_queue_empty = no_data
        || !bank_drive.strobe_clock_run;

endmodule : mbr_bank_model

`default_nettype wire

// ### mbr_bringup_test.sv
// Self-checking bench for the bring-up controller with a bank model.
// Assumes the package and all modules are compiled first.
`default_nettype none

module mbr_bringup_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                          core_clk, rst_b, start_reset, slow;
    logic                          rx_design, tx_design, no_data;
    logic                          sequence_busy, whole_interface_ok;
    logic [mbr_pkg::NUM_BANKS-1:0] pll_lock_flag, bank_sequence_complete;
    logic                          far_slice_queue_empty, queue_read_enable;
    mbr_pkg::mbr_drive_t           bank_drive;
    logic [mbr_pkg::TBYTE_W-1:0]   tristate_byte_ctrl;
    int                            n_errors, n_tests;

    localparam mbr_pkg::mbr_drive_t UP = '{default: 1'b0,
        strobe_clock_run: 1'b1, phy_clock_gate: 1'b1};

    mbr_bringup mbr_bringup_inst (.*);
    mbr_bank_model mbr_bank_model_inst (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_min(input string what, input int lo, input int got);
        n_tests++;
        if (got < lo)
        begin
            n_errors++;
            $display("unexpected %s: expected >= %0d, seen %0d", what, lo,
                     got);
        end
    endtask : chk_min

    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic wait_ok;
        while (whole_interface_ok !== 1'b1)
            @(negedge core_clk);
    endtask : wait_ok

    task automatic pulse_start;
        start_reset = 1'b1;
        @(negedge core_clk);
        start_reset = 1'b0;
    endtask : pulse_start

    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_up;
        repeat (5) @(negedge core_clk);
        chk_val("drive in reset", mbr_pkg::DRIVE_RESET, bank_drive);
        chk_val("busy in reset", 8'h01, sequence_busy);
        rst_b = 1'b1;
        wait_ok();
        chk_val("drive up", UP, bank_drive);
        chk_val("busy up", 8'h00, sequence_busy);
        repeat (4) @(negedge core_clk);
        chk_val("tbyte up", 8'h0f, tristate_byte_ctrl);
    endtask : t_power_up

    task automatic t_apply;
        int c;
        pulse_start();
        while (bank_drive.pll_reset !== 2'b11)
            @(negedge core_clk);
        chk_val("slice at pll", 8'h00, bank_drive.slice_data_reset);
        @(negedge core_clk);
        chk_val("slice next", 8'h01, bank_drive.slice_data_reset);
        chk_val("strobe kept", 8'h01, bank_drive.strobe_clock_run);
        @(negedge core_clk);
        chk_val("strobe stop", 8'h00, bank_drive.strobe_clock_run);
        chk_val("ok dropped", 8'h00, whole_interface_ok);
        c = 2;
        while (bank_drive.pll_reset !== 2'b00)
        begin
            @(negedge core_clk);
            c++;
        end
        chk_min("pll hold", mbr_pkg::PLL_RST_CYCLES, c);
        c = 0;
        while (bank_drive.phy_clock_gate !== 1'b1)
        begin
            @(negedge core_clk);
            c++;
        end
        chk_min("phy wait", 2 * mbr_pkg::SLICE_WAIT_APP - 1, c);
        chk_val("strobe idle", 8'h00, bank_drive.strobe_clock_run);
        wait_ok();
        chk_val("drive back", UP, bank_drive);
    endtask : t_apply

    task automatic t_slow;
        bit lk;
        int c;
        lk = 1'b0;
        slow = 1'b1;
        pulse_start();
        @(negedge core_clk);
        c = 1;
        while (whole_interface_ok !== 1'b1)
        begin
            if (bank_drive.slice_data_reset === 1'b1)
                lk = (pll_lock_flag === 2'b11);
            @(negedge core_clk);
            c++;
        end
        chk_val("lock seen", 8'h01, lk);
        chk_val("done flags", 8'h03, bank_sequence_complete);
        chk_min("slow span", mbr_pkg::PLL_RST_CYCLES + 60, c);
        slow = 1'b0;
    endtask : t_slow

    task automatic t_rx;
        tx_design = 1'b0;
        rx_design = 1'b1;
        repeat (5) @(negedge core_clk);
        chk_val("tbyte rx", 8'h00, tristate_byte_ctrl);
        chk_val("read empty", 8'h00, queue_read_enable);
        no_data = 1'b0;
        repeat (5) @(negedge core_clk);
        chk_val("read data", 8'h01, queue_read_enable);
        pulse_start();
        repeat (6) @(negedge core_clk);
        chk_val("read in reset", 8'h00, queue_read_enable);
        wait_ok();
        chk_val("read held", 8'h00, queue_read_enable);
        repeat (5) @(negedge core_clk);
        chk_val("read again", 8'h01, queue_read_enable);
        no_data = 1'b1;
        repeat (5) @(negedge core_clk);
        chk_val("read stop", 8'h00, queue_read_enable);
    endtask : t_rx

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end

    initial
    begin
        rst_b = 1'b0;
        start_reset = 1'b0;
        rx_design = 1'b0;
        tx_design = 1'b1;
        slow = 1'b0;
        no_data = 1'b1;
        n_errors = 0;
        n_tests = 0;
        t_power_up();
        t_apply();
        t_slow();
        t_rx();
        final_report();
    end

endmodule : mbr_bringup_test

bind mbr_bringup mbr_checker mbr_checker_inst (
    .core_clk, .rst_b, .tx_design, .whole_interface_ok, .pll_lock_flag,
    .bank_sequence_complete, .far_slice_queue_empty, .bank_drive,
    .tristate_byte_ctrl, .queue_read_enable);

`default_nettype wire
